// ===== rtl/tmr_dual_timer.sv
// Two 8-bit timer/counters with PWM; unit 2 may count oscillator pin edges.
// Assumes the oscillator pin is asynchronous and well below a quarter of mclk.
module tmr_dual_timer
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Oscillator pin for unit 2
  input wire logic oscClockPin,
  output logic oscPinsClaimed,
  // Compare outputs
  output logic unit0WaveOut,
  output logic unit0WaveOe,
  output logic unit2WaveOut,
  output logic unit2WaveOe
);

  // ==========================================================
  // Oscillator pin synchroniser and edge qualifier
  logic oscSync1;
  logic oscSync2;
  logic oscSync3;
  logic oscLevel;
  logic asyncSelect;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      oscSync1 <= 1'b0;
      oscSync2 <= 1'b0;
      oscSync3 <= 1'b0;
      oscLevel <= 1'b0;
    end else begin
      oscSync1 <= oscClockPin; // [R25]
      oscSync2 <= oscSync1;
      oscSync3 <= oscSync2;
      if (oscSync2 == oscSync3) begin
        oscLevel <= oscSync3;
      end
    end
  end

  wire oscRise = (oscSync2 == oscSync3) && oscSync3 && !oscLevel; // [R25]

  // ==========================================================
  // Per-unit state; index 0 is unit 0, index 1 is unit 2
  logic [7:0] counter [2];
  logic countDown [2];
  logic [7:0] control [2];
  logic [7:0] compareHw [2];
  logic [7:0] compareAct [2];
  logic [7:0] controlTmp [2];
  logic [7:0] compareTmp [2];
  logic [7:0] counterTmp [2];
  logic [2:0] pending [2];
  logic [1:0] edgeCount [2][3];
  logic overflowFlag [2];
  logic compareFlag [2];
  logic waveLevel [2];

  // ==========================================================
  // Write decode
  // One strobe qualified by one register index
  function automatic logic regHit(input logic strobe, input logic [3:0] addr,
                                  input logic [3:0] off);
    regHit = strobe && (addr == off);
  endfunction : regHit

  wire wrCtl0 = regHit(regWrite, regAddr, OFF_UNIT0_CONTROL);
  wire wrCnt0 = regHit(regWrite, regAddr, OFF_UNIT0_COUNTER);
  wire wrCmp0 = regHit(regWrite, regAddr, OFF_UNIT0_COMPARE);
  wire wrCtl2 = regHit(regWrite, regAddr, OFF_UNIT2_CONTROL);
  wire wrCnt2 = regHit(regWrite, regAddr, OFF_UNIT2_COUNTER);
  wire wrCmp2 = regHit(regWrite, regAddr, OFF_UNIT2_COMPARE);
  wire wrAsync = regHit(regWrite, regAddr, OFF_ASYNC_STATUS);
  wire wrFlags = regHit(regWrite, regAddr, OFF_FLAGS);

  wire [2:0] wrSlot [2];
  assign wrSlot[0] = {wrCtl0, wrCmp0, wrCnt0};
  assign wrSlot[1] = {wrCtl2, wrCmp2, wrCnt2};

  wire [1:0] clrOvf = {wrFlags && regWdata[FLG_UNIT2_OVERFLOW],
                       wrFlags && regWdata[FLG_UNIT0_OVERFLOW]};
  wire [1:0] clrCmp = {wrFlags && regWdata[FLG_UNIT2_COMPARE],
                       wrFlags && regWdata[FLG_UNIT0_COMPARE]};

  // ==========================================================
  // Async select
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      asyncSelect <= 1'b0;
    end else if (wrAsync) begin
      asyncSelect <= regWdata[AST_ASYNC_SELECT]; // [R16]
    end
  end

  assign oscPinsClaimed = asyncSelect; // [R16]

  // Output pin level for a compare match in phase-correct mode
  function automatic logic phaseLevel(input logic inv, input logic down,
                                      input logic [7:0] cmp);
    if (cmp == COUNT_BOTTOM) begin
      phaseLevel = inv; // [R11]
    end else if (cmp == COUNT_TOP) begin
      phaseLevel = !inv; // [R11]
    end else begin
      phaseLevel = inv ^ down; // [R6] [R7]
    end
  endfunction : phaseLevel

  // ==========================================================
  // Timer units
  for (genvar u = 0; u < 2; u++) begin : g_unit
    // Unit 2 alone may run from the oscillator
    wire isAsync = (u == 1) && asyncSelect;
    wire [2:0] slotDone;
    wire [2:0] slotLoad;
    for (genvar k = 0; k < 3; k++) begin : g_slot
      assign slotDone[k] = pending[u][k] && (edgeCount[u][k] == XFER_EDGES); // [R23]
      assign slotLoad[k] = isAsync ? slotDone[k] : wrSlot[u][k];
    end

    wire [7:0] counterNew = isAsync ? counterTmp[u] : regWdata;
    wire [7:0] compareNew = isAsync ? compareTmp[u] : regWdata;
    wire [7:0] controlNew = isAsync ? controlTmp[u] : regWdata;

    wire pwmOn = control[u][CTL_PWM];
    wire fastPwm = control[u][CTL_CLEAR_ON_MATCH];
    wire [1:0] outMode = {control[u][CTL_MODE_HI], control[u][CTL_MODE_LO]};
    wire clockOn = control[u][CTL_CS_HI:CTL_CS_LO] != 3'h0; // [R24]
    wire tick = clockOn && (!isAsync || oscRise); // [R16]
    wire atTop = counter[u] == COUNT_TOP;
    wire atBottom = counter[u] == COUNT_BOTTOM;
    wire matchHit = tick && (counter[u] == compareAct[u]);

    // Overflow event by mode
    wire overflowHit = tick && ((pwmOn && !fastPwm) ? (atBottom && countDown[u]) // [R13]
                                                     : atTop); // [R14]

    // Force output action only outside PWM
    wire forceHit = slotLoad[XF_CONTROL] && controlNew[CTL_FORCE] && !controlNew[CTL_PWM];

    // Next counter value
    logic [7:0] next_counter;
    logic next_down;
    always_comb begin
      next_counter = counter[u];
      next_down = countDown[u];
      if (pwmOn && !fastPwm) begin
        if (!countDown[u]) begin
          if (atTop) begin
            next_down = 1'b1; // [R4]
            next_counter = counter[u] - 8'h01;
          end else begin
            next_counter = counter[u] + 8'h01;
          end
        end else if (atBottom) begin
          next_down = 1'b0; // [R4]
          next_counter = counter[u] + 8'h01;
        end else begin
          next_counter = counter[u] - 8'h01;
        end
      end else begin
        next_down = 1'b0;
        if (!pwmOn && fastPwm && (counter[u] == compareAct[u])) begin
          next_counter = COUNT_BOTTOM;
        end else begin
          next_counter = counter[u] + 8'h01; // [R1] [R5]
        end
      end
    end

    // Counter, direction and active registers
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        counter[u] <= RST_REG;
        countDown[u] <= 1'b0;
        control[u] <= RST_REG;
        compareHw[u] <= RST_REG;
        compareAct[u] <= RST_REG;
      end else begin
        if (slotLoad[XF_COUNTER]) begin
          counter[u] <= counterNew; // [R1] [R2]
        end else if (tick) begin
          counter[u] <= next_counter;
          countDown[u] <= next_down;
        end
        if (slotLoad[XF_CONTROL]) begin
          control[u] <= controlNew & ~(8'h01 << CTL_FORCE);
        end
        if (slotLoad[XF_COMPARE]) begin
          compareHw[u] <= compareNew;
        end
        if (!pwmOn) begin
          compareAct[u] <= compareHw[u];
        end else if (tick && atTop) begin
          compareAct[u] <= compareHw[u]; // [R9]
        end
      end
    end

    // Software-side temporaries and transfer tracking
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        controlTmp[u] <= RST_REG;
        compareTmp[u] <= RST_REG;
        counterTmp[u] <= RST_REG;
        pending[u] <= 3'h0;
        for (int k = 0; k < 3; k++) begin
          edgeCount[u][k] <= 2'h0;
        end
      end else begin
        if (wrSlot[u][XF_CONTROL]) begin
          controlTmp[u] <= regWdata & ~(8'h01 << CTL_FORCE);
        end
        if (wrSlot[u][XF_COMPARE]) begin
          compareTmp[u] <= regWdata; // [R10]
        end
        if (wrSlot[u][XF_COUNTER]) begin
          counterTmp[u] <= regWdata;
        end
        for (int k = 0; k < 3; k++) begin
          if (!isAsync) begin
            pending[u][k] <= 1'b0;
            edgeCount[u][k] <= 2'h0;
          end else if (wrSlot[u][k]) begin
            pending[u][k] <= 1'b1; // [R18] [R19] [R20]
            edgeCount[u][k] <= 2'h0;
          end else if (slotDone[k]) begin
            pending[u][k] <= 1'b0; // [R18] [R19] [R20]
            edgeCount[u][k] <= 2'h0;
          end else if (pending[u][k] && oscRise) begin
            edgeCount[u][k] <= edgeCount[u][k] + 2'h1; // [R23]
          end
        end
      end
    end

    // Sticky flags; a hardware set beats a software clear
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        overflowFlag[u] <= 1'b0;
        compareFlag[u] <= 1'b0;
      end else begin
        if (overflowHit) begin
          overflowFlag[u] <= 1'b1; // [R13] [R14]
        end else if (clrOvf[u]) begin
          overflowFlag[u] <= 1'b0;
        end
        if (matchHit) begin
          compareFlag[u] <= 1'b1; // [R3]
        end else if (clrCmp[u]) begin
          compareFlag[u] <= 1'b0;
        end
      end
    end

    // Compare output pin
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        waveLevel[u] <= 1'b0;
      end else if (pwmOn && !fastPwm) begin
        if (matchHit && outMode[1]) begin
          waveLevel[u] <= phaseLevel(outMode[0], countDown[u], compareAct[u]); // [R6] [R7]
        end
      end else if (pwmOn) begin
        if (outMode[1] && tick && atTop) begin
          waveLevel[u] <= !outMode[0]; // [R8] [R12]
        end else if (outMode[1] && matchHit) begin
          waveLevel[u] <= outMode[0]; // [R8]
        end
      end else if (matchHit || forceHit) begin
        unique case (outMode)
          2'b00: waveLevel[u] <= waveLevel[u];
          2'b01: waveLevel[u] <= !waveLevel[u];
          2'b10: waveLevel[u] <= 1'b0;
          2'b11: waveLevel[u] <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // Pin drive; PWM modes 00 and 01 leave the pin disconnected
  // In PWM only the upper mode bit connects the pin; outside PWM any nonzero mode does
  function automatic logic pinDrive(input logic [7:0] ctl);
    if (ctl[CTL_PWM]) begin
      pinDrive = ctl[CTL_MODE_HI];
    end else begin
      pinDrive = ctl[CTL_MODE_HI:CTL_MODE_LO] != 2'b00;
    end
  endfunction : pinDrive

  wire drive0 = pinDrive(control[0]); // [R6]
  wire drive2 = pinDrive(control[1]); // [R6]

  assign unit0WaveOut = waveLevel[0];
  assign unit0WaveOe = drive0; // [R6]
  assign unit2WaveOut = waveLevel[1];
  assign unit2WaveOe = drive2; // [R6]

  // ==========================================================
  // Read path
  wire [7:0] asyncStatus = {4'h0, asyncSelect, pending[1][XF_COUNTER], // [R15]
                            pending[1][XF_COMPARE], pending[1][XF_CONTROL]};
  wire [7:0] flagsRead = {4'h0, compareFlag[1], overflowFlag[1],
                          compareFlag[0], overflowFlag[0]};

  logic [7:0] readMux;
  always_comb begin
    unique case (regAddr)
      OFF_UNIT0_CONTROL: readMux = control[0];
      OFF_UNIT0_COUNTER: readMux = counter[0]; // [R1]
      OFF_UNIT0_COMPARE: readMux = compareTmp[0]; // [R10]
      OFF_UNIT2_CONTROL: readMux = controlTmp[1]; // [R22]
      OFF_UNIT2_COUNTER: readMux = counter[1]; // [R22]
      OFF_UNIT2_COMPARE: readMux = compareTmp[1]; // [R10] [R22]
      OFF_ASYNC_STATUS: readMux = asyncStatus;
      OFF_FLAGS: readMux = flagsRead;
      default: readMux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= readMux;
    end
  end

endmodule : tmr_dual_timer

// ===== rtl/tmr_pkg.sv
// Constants shared by the dual 8-bit timer block.
// Assumes a single 10 MHz clock and a plain strobe register port.
//
// What the block and its software must do
// R1 - Two 8-bit counters, up or up/down, read/write
// R2 - Written counter resumes counting next timer tick
// R3 - Compare flag set cycle after match
// R4 - Phase-correct PWM counts 00 up, FF down
// R5 - Fast PWM wraps FF to 00 upward
// R6 - Phase-correct 10 clears up, sets down; 0x disconnects
// R7 - Phase-correct 11 clears down, sets up
// R8 - Fast PWM: 10 clear match/set overflow, 11 opposite
// R9 - PWM compare buffered, latched at FF
// R10 - Compare read returns latest written value
// R11 - Phase-correct compare 00/FF gives constant levels
// R12 - Fast PWM constant only at compare FF
// R13 - Phase-correct overflow flag leaving 00
// R14 - Fast PWM overflow flag on FF wrap
// R15 - Async status upper four bits read zero
// R16 - Async select bit 3 clocks unit 2 from oscillator
// R17 - Software rewrites unit 2 after async change
// R18 - Counter write sets busy bit 2 until loaded
// R19 - Compare write sets busy bit 1 until loaded
// R20 - Control write sets busy bit 0 until loaded
// R21 - Software never writes while busy set
// R22 - Counter reads live; compare/control read temporaries
// R23 - Async transfer after two oscillator rising edges
// R24 - Clock select zero stops the counter
// R25 - Oscillator-side events synchronised before software sees
package tmr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] OFF_UNIT0_CONTROL = 4'h0;
  localparam logic [3:0] OFF_UNIT0_COUNTER = 4'h1;
  localparam logic [3:0] OFF_UNIT0_COMPARE = 4'h2;
  localparam logic [3:0] OFF_UNIT2_CONTROL = 4'h3;
  localparam logic [3:0] OFF_UNIT2_COUNTER = 4'h4;
  localparam logic [3:0] OFF_UNIT2_COMPARE = 4'h5;
  localparam logic [3:0] OFF_ASYNC_STATUS = 4'h6;
  localparam logic [3:0] OFF_FLAGS = 4'h7;

  // ==========================================================
  // Control field positions
  localparam int CTL_FORCE = 7;
  localparam int CTL_PWM = 6;
  localparam int CTL_MODE_HI = 5;
  localparam int CTL_MODE_LO = 4;
  localparam int CTL_CLEAR_ON_MATCH = 3;
  localparam int CTL_CS_HI = 2;
  localparam int CTL_CS_LO = 0;

  // Async status field positions
  localparam int AST_ASYNC_SELECT = 3;
  localparam int AST_COUNTER_BUSY = 2;
  localparam int AST_COMPARE_BUSY = 1;
  localparam int AST_CONTROL_BUSY = 0;

  // Flag register positions, write one to clear
  localparam int FLG_UNIT0_OVERFLOW = 0;
  localparam int FLG_UNIT0_COMPARE = 1;
  localparam int FLG_UNIT2_OVERFLOW = 2;
  localparam int FLG_UNIT2_COMPARE = 3;

  // ==========================================================
  // Reset values and count limits
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [1:0] XFER_EDGES = 2'h2;

  // Transfer slots of the unit 2 temporaries
  localparam int XF_COUNTER = 0;
  localparam int XF_COMPARE = 1;
  localparam int XF_CONTROL = 2;

endpackage : tmr_pkg

// ===== test/tmr_dual_timer_asserts.sv
// Concurrent checks on the ports of the dual timer block.
// Assumes one clock domain; bound to every instance of the timer top.
module tmr_dual_timer_asserts
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  // Pins
  input wire logic oscClockPin,
  input wire logic oscPinsClaimed,
  input wire logic unit0WaveOut,
  input wire logic unit0WaveOe,
  input wire logic unit2WaveOut,
  input wire logic unit2WaveOe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  wire logic rdStatus = regRead && regAddr == OFF_ASYNC_STATUS;

  // ==========================================================
  // Status register
  a_status_upper_zero: assert property (rdStatus |=> regRdata[7:4] == 4'h0)
    else $error("status upper bits not zero");
  a_select_claims_pins: assert property (regWrite && regAddr == OFF_ASYNC_STATUS
    |=> oscPinsClaimed == $past(regWdata[AST_ASYNC_SELECT])) else $error("pin claim wrong");
  a_select_reads_back: assert property (rdStatus
    |=> regRdata[AST_ASYNC_SELECT] == $past(oscPinsClaimed)) else $error("select readback");
  // Settled sync mode: no transfer can be pending
  a_sync_never_busy: assert property (rdStatus && !oscPinsClaimed && $past(!oscPinsClaimed)
    |=> regRdata[2:0] == 3'h0) else $error("busy flag in sync mode");
  a_counter_busy_set: assert property (oscPinsClaimed && regWrite &&
    regAddr == OFF_UNIT2_COUNTER ##1 rdStatus |=> regRdata[AST_COUNTER_BUSY])
    else $error("counter busy not set");
  a_compare_busy_set: assert property (oscPinsClaimed && regWrite &&
    regAddr == OFF_UNIT2_COMPARE ##1 rdStatus |=> regRdata[AST_COMPARE_BUSY])
    else $error("compare busy not set");
  a_control_busy_set: assert property (oscPinsClaimed && regWrite &&
    regAddr == OFF_UNIT2_CONTROL ##1 rdStatus |=> regRdata[AST_CONTROL_BUSY])
    else $error("control busy not set");

  // ==========================================================
  // Compare readback and pin enables
  a_compare_reads_back: assert property (regWrite && (regAddr == OFF_UNIT0_COMPARE ||
    regAddr == OFF_UNIT2_COMPARE) ##1 regRead && $stable(regAddr)
    |=> regRdata == $past(regWdata, 2)) else $error("compare readback not latest write");
  a_unit0_pin_enable: assert property (regWrite && regAddr == OFF_UNIT0_CONTROL &&
    regWdata[CTL_PWM] |=> unit0WaveOe == $past(regWdata[CTL_MODE_HI]))
    else $error("unit0 pin enable wrong");
  a_unit2_pin_enable: assert property (!oscPinsClaimed && regWrite &&
    regAddr == OFF_UNIT2_CONTROL && regWdata[CTL_PWM]
    |=> unit2WaveOe == $past(regWdata[CTL_MODE_HI])) else $error("unit2 pin enable wrong");
endmodule : tmr_dual_timer_asserts

bind tmr_dual_timer tmr_dual_timer_asserts u_asserts (
  .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .oscClockPin(oscClockPin),
  .oscPinsClaimed(oscPinsClaimed), .unit0WaveOut(unit0WaveOut), .unit0WaveOe(unit0WaveOe),
  .unit2WaveOut(unit2WaveOut), .unit2WaveOe(unit2WaveOe));

// ===== test/tb_top.sv
// Self-checking bench: register traffic, PWM duty per mode, async unit 2.
// Assumes the package and the bound checker are compiled before it.
`define CHK(name, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("mismatch %s expected %0h seen %0h", name, exp, got); end end

module tb_top
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0, oscClockPin = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic oscPinsClaimed, unit0WaveOut, unit0WaveOe, unit2WaveOut, unit2WaveOe;
  int n_errors = 0;
  int checked = 0;
  logic [31:0] seed = 32'h0000_370b;

  always #50 mclk = ~mclk;
  // Free-running crystal, well below a quarter of mclk, phase unrelated
  always #653 oscClockPin = ~oscClockPin;

  tmr_dual_timer dut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .oscClockPin(oscClockPin),
    .oscPinsClaimed(oscPinsClaimed), .unit0WaveOut(unit0WaveOut), .unit0WaveOe(unit0WaveOe),
    .unit2WaveOut(unit2WaveOut), .unit2WaveOe(unit2WaveOe));

  // ==========================================================
  // Helpers
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  function automatic int period(input logic [7:0] ctl);
    return ctl[CTL_CLEAR_ON_MATCH] ? 256 : 510;
  endfunction : period

  // High cycles per period: fast mode high from wrap to match, phase mode around bottom
  function automatic int expHigh(input logic [7:0] ctl, input logic [7:0] c);
    int hi;
    hi = ctl[CTL_CLEAR_ON_MATCH] ? int'(c) + 1 : 2 * int'(c);
    return ctl[CTL_MODE_LO] ? period(ctl) - hi : hi;
  endfunction : expHigh

  // Strobes are set once per edge so back-to-back calls never double-drive
  task wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task rd(input logic [3:0] a, output logic [7:0] v);
    regAddr <= a;
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(posedge mclk);
    v = regRdata;
  endtask : rd

  task idle(input int n);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask : idle

  task results();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  initial begin
    #10_000_000;
    n_errors++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] v, d, c, ctl;
    logic [3:0] aCtl, aCnt, aCmp;
    int g, hi, k;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), v);
      `CHK("reset read", 8'h00, v)
    end
    for (int u = 0; u < 2; u++) begin
      aCtl = u ? OFF_UNIT2_CONTROL : OFF_UNIT0_CONTROL;
      aCnt = u ? OFF_UNIT2_COUNTER : OFF_UNIT0_COUNTER;
      d = rnd();
      wr(aCnt, d);
      idle(5);
      rd(aCnt, v);
      `CHK("stopped count", d, v)
      wr(aCtl, 8'h01);
      for (int i = 0; i < 6; i++) begin
        d = rnd();
        g = int'(rnd() % 8'd4);
        wr(aCnt, d);
        if (g > 0) idle(g);
        rd(aCnt, v);
        `CHK("count", d + 8'(g), v)
      end
    end
    wr(OFF_UNIT0_CONTROL, 8'h08);
    wr(OFF_UNIT0_COMPARE, 8'h03);
    wr(OFF_UNIT0_COUNTER, 8'h00);
    wr(OFF_FLAGS, 8'hFF);
    wr(OFF_UNIT0_CONTROL, 8'h09);
    idle(6);
    rd(OFF_FLAGS, v);
    `CHK("compare flag", 2'b10, v[1:0])
    // PWM duty for mode bit pairs 10 and 11 in phase-correct and fast PWM, and the 00/FF corners
    for (int u = 0; u < 2; u++) begin
      for (int m = 0; m < 4; m++) begin
        for (int j = 0; j < 3; j++) begin
          ctl = 8'h61 | (m[0] ? 8'h10 : 8'h00) | (m[1] ? 8'h08 : 8'h00);
          c = (j == 0) ? 8'h00 : ((j == 1) ? 8'hFF : rnd());
          wr(u ? OFF_UNIT2_CONTROL : OFF_UNIT0_CONTROL, ctl);
          wr(u ? OFF_UNIT2_COMPARE : OFF_UNIT0_COMPARE, c);
          rd(u ? OFF_UNIT2_COMPARE : OFF_UNIT0_COMPARE, v);
          `CHK("buffered compare", c, v)
          idle(1100);
          hi = 0;
          repeat (period(ctl)) begin
            @(posedge mclk);
            hi += int'((u ? unit2WaveOut : unit0WaveOut) === 1'b1);
          end
          `CHK("duty", expHigh(ctl, c), hi)
          wr(OFF_FLAGS, 8'hFF);
          idle(period(ctl));
          rd(OFF_FLAGS, v);
          `CHK("overflow", 1'b1, v[u ? FLG_UNIT2_OVERFLOW : FLG_UNIT0_OVERFLOW])
        end
      end
    end
    // Asynchronous unit 2
    wr(OFF_ASYNC_STATUS, 8'h08);
    rd(OFF_ASYNC_STATUS, v);
    `CHK("select", 8'h08, v)
    `CHK("pins claimed", 1'b1, oscPinsClaimed)
    c = rnd();
    d = rnd();
    for (int r = 0; r < 3; r++) begin
      wr((r == 0) ? OFF_UNIT2_CONTROL : ((r == 1) ? OFF_UNIT2_COMPARE : OFF_UNIT2_COUNTER),
        (r == 0) ? 8'h01 : ((r == 1) ? c : d));
      rd(OFF_ASYNC_STATUS, v);
      `CHK("busy", 8'h08 | 8'(1 << r), v)
      k = 0;
      // Next write waits for the transfer to finish
      do begin
        rd(OFF_ASYNC_STATUS, v);
        k++;
      end while (v !== 8'h08 && k < 100);
      `CHK("settled", 8'h08, v)
    end
    rd(OFF_UNIT2_COUNTER, v);
    `CHK("live count", 1'b1, (v - d) < 8'd4)
    rd(OFF_UNIT2_COMPARE, v);
    `CHK("compare temp", c, v)
    rd(OFF_UNIT2_CONTROL, v);
    `CHK("control temp", 8'h01, v)
    wr(OFF_ASYNC_STATUS, 8'h00);
    idle(1);
    `CHK("pins released", 1'b0, oscPinsClaimed)
    wr(OFF_UNIT2_CONTROL, 8'h00);
    idle(2);
    results();
  end
endmodule : tb_top
